// ==== drs_periph_model.sv ====
// Model of the on-chip peripherals that raise request strobes
`timescale 1ns/1ps
`default_nettype none
module drs_periph_model (
    // Command from the bench
    input  wire logic        clock,
    input  wire logic        fire,
    input  wire logic [5:0]  src,
    // One strobe per request source
    output var  logic [50:0] rq
);
    // Strobes leave a flop like real peripherals; index 63 raises all at once
    always_ff @(posedge clock) begin
        rq <= fire ? ((src == 6'h3f) ? '1 : (51'h1 << src)) : '0;
    end
endmodule : drs_periph_model
`default_nettype wire

// ==== drs_pkg.sv ====
// Constants for the DMA request source selector
`default_nettype none
package drs_pkg;

    // ------------------------------------------------------------
    // Register word indices (byte address is four times these)
    // ------------------------------------------------------------
    localparam logic [2:0] IDX_PRIMARY   = 3'h0;
    localparam logic [2:0] IDX_SECONDARY = 3'h1;
    localparam logic [2:0] IDX_CONTROL   = 3'h2;
    localparam logic [2:0] IDX_SW_TRIG   = 3'h3;
    localparam logic [2:0] IDX_STATUS    = 3'h4;

    // ------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------
    localparam logic [31:0] SEL_MASK     = 32'h1f1f1f1f;
    localparam logic [31:0] CTRL_MASK    = 32'h00007f03;
    localparam logic [31:0] SEL_RESET    = 32'h00000000;
    localparam logic [31:0] CTRL_RESET   = 32'h00000000;
    localparam int          CTRL_BUS_BIT = 0;
    localparam int          CTRL_I2C_BIT = 1;
    localparam int          CTRL_ACK_LSB = 8;
    localparam int          STAT_REQ_LSB = 8;
    localparam logic [6:0]  PIN_IDLE     = 7'h7f;
    localparam int          PIN_HI_BASE  = 4;

    // ------------------------------------------------------------
    // Select codes
    // ------------------------------------------------------------
    localparam logic [4:0] SEL_NONE    = 5'h00;
    localparam logic [4:0] SEL_FALL    = 5'h01;
    localparam logic [4:0] SEL_BOTH    = 5'h02;
    localparam logic [4:0] SEL_TMRA0   = 5'h03;
    localparam logic [4:0] SEL_TMRB0   = 5'h08;
    localparam logic [4:0] SEL_U0_TX   = 5'h0e;
    localparam logic [4:0] SEL_U2_TX   = 5'h12;
    localparam logic [4:0] SEL_U3_TX   = 5'h14;
    localparam logic [4:0] SEL_AD0     = 5'h18;
    localparam logic [4:0] SEL_MFIO    = 5'h19;
    localparam logic [4:0] SEL_U7_TX   = 5'h18;
    localparam logic [4:0] SEL_U7_RX   = 5'h19;
    localparam logic [4:0] SEL_U8_TX   = 5'h1a;
    localparam logic [4:0] SEL_U8_RX   = 5'h1b;
    localparam int         MFIO_COUNT  = 12;
    localparam logic [15:0] MFIO_BASE  = 16'h9270;

endpackage : drs_pkg
`default_nettype wire

// ==== drs_select.sv ====
// DMA request source selector with Avalon-MM register slave
//
// Implementation choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module drs_select #(
    parameter int CH = 4
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // Avalon-MM slave
    input  wire logic [2:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [3:0]  byteenable,
    input  wire logic [31:0] writedata,
    output var  logic [31:0] readdata,
    output var  logic        waitrequest,
    // External request pins
    input  wire logic [3:0]  ext_request_pin_lo,
    input  wire logic        ext_request_pin_6,
    input  wire logic        ext_request_pin_7,
    input  wire logic        ext_request_pin_8,
    // Peripheral requests
    input  wire logic [4:0]  timer_a_req,
    input  wire logic [5:0]  timer_b_req,
    input  wire logic [6:0]  serial_tx_req,
    input  wire logic [6:0]  serial_rx_req,
    input  wire logic [6:0]  serial_ack_req,
    input  wire logic        serial_unit_7_tx,
    input  wire logic        serial_unit_7_rx,
    input  wire logic        serial_unit_8_tx,
    input  wire logic        serial_unit_8_rx,
    input  wire logic        i2c_if_req,
    input  wire logic        i2c_line_req,
    input  wire logic        adc0_req,
    input  wire logic [11:0] mfio_req,
    // Requests to the channel engine
    output var  logic [3:0]  dma_request
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic        wait_q;
        logic [31:0] rdata;
        logic [31:0] prim;
        logic [31:0] sec;
        logic [31:0] ctrl;
        logic [6:0]  sync1;
        logic [6:0]  sync2;
        logic [6:0]  sync3;
        logic [6:0]  level;
        logic [3:0]  req;
    } drs_state_t;

    drs_state_t st_q;
    drs_state_t st_d;

    logic [6:0] pin_raw;
    logic [6:0] fall;
    logic [6:0] chg;
    logic [6:0] rx_eff;
    logic [3:0] sw_fire;
    logic       acc;

    assign pin_raw = {ext_request_pin_8, ext_request_pin_7,
                      ext_request_pin_6, ext_request_pin_lo};
    assign acc     = (read | write) & ~st_q.wait_q;

    // Byte-lane masked write
    function automatic logic [31:0] drs_be_wr(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction : drs_be_wr

    // Request number for the multi-function I/O codes
    function automatic logic [3:0] drs_mfio_idx(input logic [1:0] ch,
                                                input logic [4:0] code);
        logic [4:0] n;
        n = 5'(drs_pkg::MFIO_BASE[ch*4 +: 4]) + (code - drs_pkg::SEL_MFIO);
        if (n >= 5'(drs_pkg::MFIO_COUNT)) begin
            n = n - 5'(drs_pkg::MFIO_COUNT);
        end
        return n[3:0];
    endfunction : drs_mfio_idx

    // ------------------------------------------------------------
    // Pin edge detection
    // ------------------------------------------------------------
    // edges from pins only
    // Level changes only once stages two and three agree, so a
    // glitch shorter than a clock never reaches a channel.
    always_comb begin
        for (int p = 0; p < 7; p++) begin
            chg[p]  = (st_q.sync2[p] == st_q.sync3[p]) &&
                      (st_q.sync3[p] != st_q.level[p]);
            fall[p] = chg[p] && !st_q.sync3[p];
        end
    end

    // Receive source per serial unit
    always_comb begin
        for (int u = 0; u < 7; u++) begin
            rx_eff[u] = st_q.ctrl[drs_pkg::CTRL_ACK_LSB + u] ?
                        serial_ack_req[u] : serial_rx_req[u];
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [4:0] p;
        logic [4:0] s;
        logic       r;
        logic       u2tx;
        logic       u2rx;
        logic [2:0] hi;
        p    = '0;
        s    = '0;
        r    = 1'b0;
        hi   = '0;
        st_d = st_q;
        u2tx = st_q.ctrl[drs_pkg::CTRL_I2C_BIT] ? i2c_if_req : serial_tx_req[2];
        u2rx = st_q.ctrl[drs_pkg::CTRL_I2C_BIT] ? i2c_line_req : rx_eff[2];

        // Three-stage pin synchroniser and settled level
        st_d.sync1 = pin_raw;
        st_d.sync2 = st_q.sync1;
        st_d.sync3 = st_q.sync2;
        for (int q = 0; q < 7; q++) begin
            if (chg[q]) begin
                st_d.level[q] = st_q.sync3[q];
            end
        end

        // Bus handshake: one wait cycle, then the answer cycle
        st_d.wait_q = ~((read | write) & st_q.wait_q);
        if ((read | write) && st_q.wait_q) begin
            case (address)
                drs_pkg::IDX_PRIMARY:   st_d.rdata = st_q.prim;
                drs_pkg::IDX_SECONDARY: st_d.rdata = st_q.sec;
                drs_pkg::IDX_CONTROL:   st_d.rdata = st_q.ctrl;
                drs_pkg::IDX_STATUS: begin
                    st_d.rdata = '0;
                    st_d.rdata[6:0] = st_q.level;
                    st_d.rdata[drs_pkg::STAT_REQ_LSB +: 4] = st_q.req;
                end
                default: st_d.rdata = '0;
            endcase
        end
        sw_fire = '0;
        if (write && acc) begin
            case (address)
                drs_pkg::IDX_PRIMARY: st_d.prim =
                    drs_be_wr(st_q.prim, writedata, byteenable) & drs_pkg::SEL_MASK;
                drs_pkg::IDX_SECONDARY: st_d.sec =
                    drs_be_wr(st_q.sec, writedata, byteenable) & drs_pkg::SEL_MASK;
                drs_pkg::IDX_CONTROL: st_d.ctrl =
                    drs_be_wr(st_q.ctrl, writedata, byteenable) & drs_pkg::CTRL_MASK;
                drs_pkg::IDX_SW_TRIG: sw_fire = byteenable[0] ? writedata[3:0] : 4'h0;
                default: ;
            endcase
        end

        // Per-channel source selection
        for (int c = 0; c < CH; c++) begin
            p = st_q.prim[c*8 +: 5];
            s = st_q.sec[c*8 +: 5];
            r = 1'b0;
            if (p == drs_pkg::SEL_NONE) begin
                // Channel 3 has no pin here; wrap keeps the index inside the vector
                hi = 3'(drs_pkg::PIN_HI_BASE + (c % 3));
                case (s)
                    drs_pkg::SEL_NONE: r = sw_fire[c];
                    drs_pkg::SEL_FALL: r = (c < 3) && fall[hi];
                    drs_pkg::SEL_BOTH: r = (c < 3) && chg[hi];
                    drs_pkg::SEL_U7_TX: r = (c == 0) && serial_unit_7_tx;
                    drs_pkg::SEL_U8_TX: r = (c == 1) && serial_unit_8_tx;
                    drs_pkg::SEL_U7_RX: r = (c == 0) && serial_unit_7_rx;
                    drs_pkg::SEL_U8_RX: r = (c == 1) && serial_unit_8_rx;
                    default: r = 1'b0;
                endcase
            end else if (p == drs_pkg::SEL_FALL || p == drs_pkg::SEL_BOTH) begin
                r = (p == drs_pkg::SEL_FALL) ? fall[c] : chg[c];
                // pin 3 lost to data bus
                if (c == 3 && st_q.ctrl[drs_pkg::CTRL_BUS_BIT]) begin
                    r = 1'b0;
                end
            end else if (p < drs_pkg::SEL_TMRB0) begin
                r = timer_a_req[3'(p - drs_pkg::SEL_TMRA0)];
            end else if (p < drs_pkg::SEL_U0_TX) begin
                r = timer_b_req[3'(p - drs_pkg::SEL_TMRB0)];
            end else if (p < drs_pkg::SEL_U3_TX) begin
                case (p)
                    drs_pkg::SEL_U2_TX:      r = u2tx;
                    drs_pkg::SEL_U2_TX + 1:  r = u2rx;
                    default: begin
                        // Units 0 and 1: even code transmit, odd receive
                        if (p[0]) begin
                            r = rx_eff[p[2:1] - 2'h3];
                        end else begin
                            r = serial_tx_req[p[2:1] - 2'h3];
                        end
                    end
                endcase
            end else if (p < drs_pkg::SEL_AD0) begin
                // Units 3/4 on channels 0-1, units 5/6 on channels 2-3
                hi = 3'(3 + p[1] + ((c >= 2) ? 2 : 0));
                r  = p[0] ? rx_eff[hi] : serial_tx_req[hi];
            end else if (p == drs_pkg::SEL_AD0) begin
                r = adc0_req;
            end else begin
                r = mfio_req[drs_mfio_idx(2'(c), p)];
            end
            st_d.req[c] = r;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st_q        <= '0;
            st_q.wait_q <= 1'b1;
            st_q.prim   <= drs_pkg::SEL_RESET;
            st_q.sec    <= drs_pkg::SEL_RESET;
            st_q.ctrl   <= drs_pkg::CTRL_RESET;
            st_q.sync1  <= drs_pkg::PIN_IDLE;
            st_q.sync2  <= drs_pkg::PIN_IDLE;
            st_q.sync3  <= drs_pkg::PIN_IDLE;
            st_q.level  <= drs_pkg::PIN_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    assign readdata    = st_q.rdata;
    assign waitrequest = st_q.wait_q;
    assign dma_request = st_q.req;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    chk_sw_only: assert property (
        st_q.prim[4:0] == 5'h00 && st_q.sec[4:0] == 5'h00 && !sw_fire[0]
        |=> !dma_request[0]) else $error("request without software trigger");
    chk_fall_pin: assert property (
        st_q.prim[12:8] == 5'h00 && st_q.sec[12:8] == 5'h01
        |=> dma_request[1] == $past(fall[5])) else $error("pin 7 falling edge lost");
    chk_both_pin: assert property (
        st_q.prim[4:0] == 5'h00 && st_q.sec[4:0] == 5'h02 && chg[4]
        |=> dma_request[0]) else $error("pin 6 edge lost");
    chk_tx_unit7: assert property (
        st_q.prim[4:0] == 5'h00 && st_q.sec[4:0] == 5'h18
        |=> dma_request[0] == $past(serial_unit_7_tx)) else $error("unit 7 tx route");
    chk_rx_unit8: assert property (
        st_q.prim[12:8] == 5'h00 && st_q.sec[12:8] == 5'h1b
        |=> dma_request[1] == $past(serial_unit_8_rx)) else $error("unit 8 rx route");
    chk_bus_pin: assert property (
        st_q.ctrl[0] && (st_q.prim[28:24] == 5'h01 || st_q.prim[28:24] == 5'h02)
        |=> !dma_request[3]) else $error("pin 3 used while on data bus");
    chk_ack_route: assert property (
        st_q.prim[4:0] == 5'h0f && st_q.ctrl[8]
        |=> dma_request[0] == $past(serial_ack_req[0])) else $error("ack route");
    chk_i2c_route: assert property (
        st_q.prim[4:0] == 5'h12 && st_q.ctrl[1]
        |=> dma_request[0] == $past(i2c_if_req)) else $error("i2c route");
    chk_mfio_wrap: assert property (
        st_q.prim[28:24] == 5'h1c
        |=> dma_request[3] == $past(mfio_req[0])) else $error("io request wrap");
    chk_reserved_q: assert property (
        st_q.prim[28:24] == 5'h00 && st_q.sec[28:24] == 5'h01
        |=> !dma_request[3]) else $error("reserved code requested");
    chk_bus_wait: assert property (
        (read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
        else $error("bus answer timing");

endmodule : drs_select
`default_nettype wire

// ==== tb_dma_request_source_select.sv ====
// Self-checking bench for the DMA request source selector
`timescale 1ns/1ps
`default_nettype none
module tb_dma_request_source_select;
    logic        clock, waitrequest;
    logic        rst_n = 1'b0, read = 1'b0, write = 1'b0, fire = 1'b0;
    logic [2:0]  address = 3'h0;
    logic [3:0]  dma_request;
    logic [31:0] writedata = 32'h0, readdata, rd;
    logic [5:0]  src = 6'h0;
    logic [6:0]  pin_lvl = 7'h7f;
    logic [50:0] rq;
    int          num_errors = 0, n_compared = 0;
    drs_periph_model model_u (.clock, .fire, .src, .rq);
    drs_select dut_u (
        .clock, .rst_n, .address, .read, .write, .byteenable(4'hf), .writedata,
        .readdata, .waitrequest, .ext_request_pin_lo(pin_lvl[3:0]),
        .ext_request_pin_6(pin_lvl[4]), .ext_request_pin_7(pin_lvl[5]),
        .ext_request_pin_8(pin_lvl[6]), .timer_a_req(rq[4:0]), .timer_b_req(rq[10:5]),
        .serial_tx_req(rq[17:11]), .serial_rx_req(rq[24:18]), .serial_ack_req(rq[31:25]),
        .serial_unit_7_tx(rq[32]), .serial_unit_7_rx(rq[33]), .serial_unit_8_tx(rq[34]),
        .serial_unit_8_rx(rq[35]), .i2c_if_req(rq[36]), .i2c_line_req(rq[37]),
        .adc0_req(rq[38]), .mfio_req(rq[50:39]), .dma_request
    );
    // 125 MHz clock
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Avalon transfer: request held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
        address   <= a;
        writedata <= d;
        write     <= wr;
        read      <= ~wr;
        @(posedge clock);
        while (waitrequest !== 1'b0) @(posedge clock);
        rd = readdata;
        write <= 1'b0;
        read  <= 1'b0;
        @(posedge clock);
    endtask : bus
    // Collect every request seen over a window longer than any latency
    task automatic watch(input logic [3:0] exp);
        logic [3:0] seen;
        // A trigger write's one-cycle request already stands at the closing edge
        seen = dma_request;
        repeat (8) begin
            @(posedge clock);
            seen = seen | dma_request;
        end
        check({28'h0, seen}, {28'h0, exp});
    endtask : watch
    task automatic hit(input logic [5:0] s, input logic [3:0] exp);
        src  <= s;
        fire <= 1'b1;
        @(posedge clock);
        fire <= 1'b0;
        watch(exp);
    endtask : hit
    task automatic pin(input int i, input logic v, input logic [3:0] exp);
        pin_lvl[i] <= v;
        watch(exp);
    endtask : pin
    task automatic cfg(input logic [31:0] p, input logic [31:0] s, input logic [31:0] c);
        bus(1'b1, drs_pkg::IDX_PRIMARY, p);
        bus(1'b1, drs_pkg::IDX_SECONDARY, s);
        bus(1'b1, drs_pkg::IDX_CONTROL, c);
    endtask : cfg
    // Reset value, field masking and an unmapped place
    task automatic s_regs;
        bus(1'b0, drs_pkg::IDX_CONTROL, 32'h0);
        check(rd, drs_pkg::CTRL_RESET);
        bus(1'b1, drs_pkg::IDX_PRIMARY, 32'hffffffff);
        bus(1'b0, drs_pkg::IDX_PRIMARY, 32'h0);
        check(rd, drs_pkg::SEL_MASK);
        bus(1'b1, 3'h5, 32'hffffffff);
        bus(1'b0, 3'h5, 32'h0);
        check(rd, 32'h0);
    endtask : s_regs
    task automatic s_secondary;
        cfg(32'h0, 32'h00001a18, 32'h0);
        hit(6'd32, 4'h1);
        hit(6'd34, 4'h2);
        cfg(32'h0, 32'h00001b19, 32'h0);
        hit(6'd33, 4'h1);
        hit(6'd35, 4'h2);
        cfg(32'h0000000e, 32'h00001b19, 32'h0);
        hit(6'd33, 4'h0);
        hit(6'd11, 4'h1);
        cfg(32'h0, 32'h1c1c0303, 32'h0);
        hit(6'h3f, 4'h0);
        bus(1'b1, drs_pkg::IDX_SW_TRIG, 32'h0000000f);
        watch(4'h0);
        cfg(32'h0, 32'h0, 32'h0);
        bus(1'b1, drs_pkg::IDX_SW_TRIG, 32'h0000000f);
        watch(4'hf);
        hit(6'h3f, 4'h0);
    endtask : s_secondary
    // pin edge modes, channel 3 refusals, pin 3 on the data bus
    task automatic s_pins;
        for (int m = 1; m < 3; m++) begin
            cfg(32'h0, 32'h01010101 * m, 32'h0);
            for (int i = 0; i < 3; i++) begin
                pin(4 + i, 1'b0, 4'h1 << i);
                pin(4 + i, 1'b1, (m == 2) ? 4'h1 << i : 4'h0);
            end
        end
        cfg(32'h01000000, 32'h0, 32'h1);
        pin(3, 1'b0, 4'h0);
        pin(3, 1'b1, 4'h0);
        bus(1'b1, drs_pkg::IDX_CONTROL, 32'h0);
        pin(3, 1'b0, 4'h8);
    endtask : s_pins
    // shared receive or acknowledge source, serial or I2C routing
    task automatic s_serial;
        cfg(32'h0000000f, 32'h0, 32'h0);
        hit(6'd18, 4'h1);
        hit(6'd25, 4'h0);
        bus(1'b1, drs_pkg::IDX_CONTROL, 32'h00000100);
        hit(6'd18, 4'h0);
        hit(6'd25, 4'h1);
        cfg(32'h00000012, 32'h0, 32'h2);
        hit(6'd36, 4'h1);
        hit(6'd13, 4'h0);
        bus(1'b1, drs_pkg::IDX_CONTROL, 32'h0);
        hit(6'd13, 4'h1);
    endtask : s_serial
    // I/O request codes rotate per channel and wrap at twelve
    task automatic s_mfio;
        int base [4] = '{0, 7, 2, 9};
        int b;
        cfg(32'h0, 32'h0, 32'h0);
        for (int ch = 0; ch < 4; ch++) begin
            for (int c = 0; c < 7; c++) begin
                bus(1'b1, drs_pkg::IDX_PRIMARY, (32'h19 + c) << (8 * ch));
                b = (base[ch] + c) % 12;
                hit(6'(39 + b), 4'h1 << ch);
                hit(6'(39 + (b + 1) % 12), 4'h0);
            end
        end
    endtask : s_mfio
    // Primary timer, converter and unit 3, 5 and 6 codes, I2C line route, read-only status and write-only trigger words
    task automatic s_primary;
        cfg(32'h16150803, 32'h0, 32'h0);
        hit(6'd0, 4'h1);
        hit(6'd5, 4'h2);
        hit(6'd23, 4'h4);
        hit(6'd17, 4'h8);
        cfg(32'h00131418, 32'h0, 32'h2);
        hit(6'd38, 4'h1);
        hit(6'd14, 4'h2);
        hit(6'd37, 4'h4);
        hit(6'd20, 4'h0);
        bus(1'b0, drs_pkg::IDX_STATUS, 32'h0);
        check(rd, 32'h00000077);
        bus(1'b0, drs_pkg::IDX_SW_TRIG, 32'h0);
        check(rd, 32'h0);
    endtask : s_primary
    task automatic complete_run;
        $display("Errors %0d of %0d compares", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run
    // Reset for 20 cycles, then the scenarios in turn
    initial begin
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        repeat (4) @(posedge clock);
        s_regs();
        s_secondary();
        s_pins();
        s_serial();
        s_mfio();
        s_primary();
        complete_run();
    end
    // Watchdog: the whole run needs a few thousand cycles at most
    initial begin
        repeat (10000) @(posedge clock);
        num_errors++;
        complete_run();
    end
endmodule : tb_dma_request_source_select
`default_nettype wire
